// ### src/scr_serial_control.sv
/*
 * Serial control register with its transmitter, receiver and serial clock pin logic.
 * Assumes a plain register port on i_clk, and serial pins (rxd, sck input) that are
 * asynchronous to i_clk and are therefore synchronised before use.
 */
// Design decisions made here: strobed register access and the address map.
// Function
// - the transmit-empty interrupt request is raised only while its enable bit 7 is set.
// - bit 6 enables both the receive-full and the receive-error interrupt requests.
// - bit 5 lets the transmitter run; while it is clear no frame is sent.
// - bit 4 lets the receiver run; while it is clear nothing is received.
// - the multiprocessor filter acts only in asynchronous mode with multiprocessor format on.
// - while filtering, frames with multiprocessor bit 0 are dropped.
// - while filtering, frames with multiprocessor bit 0 set no receive-full, framing or overrun flag.
// - a frame with multiprocessor bit 1 clears the filter enable and is received normally.
// - the transmit-end interrupt request is raised only while its enable bit 2 is set.
// - asynchronous with clock select 00 uses the internal clock and leaves the pin undriven.
// - asynchronous with clock select 01 drives a bit-rate clock out on the pin.
// - asynchronous with clock select 1x takes a sixteen-times bit clock from the pin.
// - synchronous with clock select 0x drives the internal transfer clock on the pin.
// - synchronous with clock select 1x uses the pin as the transfer clock input.
module scr_serial_control #(
   parameter int unsigned BAUD = 115200
) (
   input  wire logic       i_clk,
   input  wire logic       i_rstn,
   input  wire logic [2:0] i_addr,
   input  wire logic [7:0] i_wdata,
   input  wire logic       i_wr,
   input  wire logic       i_rd,
   output logic [7:0]      o_rdata,
   input  wire logic       i_rxd,
   output logic            o_txd,
   input  wire logic       i_sck,
   output logic            o_sck,
   output logic            o_sck_oe,
   output logic            o_tx_empty_irq,
   output logic            o_rx_full_irq,
   output logic            o_rx_error_irq,
   output logic            o_tx_end_irq
);

   localparam int unsigned DIV_RAW = scr_pkg::CLK_HZ / (BAUD * scr_pkg::TICKS_PER_BIT);
   localparam int unsigned DIV16   = (DIV_RAW < 1) ? 1 : DIV_RAW;
   localparam logic [15:0] DIV_LAST = 16'(DIV16 - 1);

   typedef enum logic {TX_IDLE, TX_BUSY} scr_tx_state_type;
   typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS} scr_rx_state_type;

   // sticky flag: a hardware set wins over a software clear in the same cycle
   function automatic logic sticky_next(input logic q, input logic set, input logic clr);
      sticky_next = set || (q && !clr);
   endfunction : sticky_next

   scr_pkg::scr_ctrl_type ctrl_q;
   scr_pkg::scr_ctrl_type ctrl_d;
   scr_pkg::scr_mode_type mode_q;
   logic                  overrun_q;
   logic                  framing_q;
   logic [7:0]            rdata_q;
   logic [7:0]            rdata_d;
   logic [1:0]            rxd_s_q;
   logic [1:0]            sck_s_q;
   logic                  sck_d_q;
   logic [15:0]           div_q;
   logic [3:0]            phase_q;
   logic                  sck_q;
   logic                  sck_oe_q;

   scr_tx_state_type      tx_state_q;
   scr_tx_state_type      tx_state_d;
   logic [10:0]           tx_sh_q;
   logic [10:0]           tx_sh_d;
   logic [3:0]            tx_cnt_q;
   logic [3:0]            tx_cnt_d;
   logic [3:0]            tx_tick_q;
   logic [3:0]            tx_tick_d;

   scr_rx_state_type      rx_state_q;
   scr_rx_state_type      rx_state_d;
   logic [9:0]            rx_sh_q;
   logic [9:0]            rx_sh_d;
   logic [3:0]            rx_idx_q;
   logic [3:0]            rx_idx_d;
   logic [3:0]            rx_tick_q;
   logic [3:0]            rx_tick_d;
   logic                  rx_done;

   scr_pkg::scr_word_type txb_data;
   scr_pkg::scr_word_type rxb_out;
   scr_pkg::scr_word_type rx_word;
   scr_pkg::scr_word_type txb_head;
   logic                  txb_ready;
   logic                  txb_valid;
   logic                  rxb_ready;
   logic                  rxb_valid;

   // register decode
   wire wr_ctrl = i_wr && (i_addr == scr_pkg::CTRL_OFS);
   wire wr_mode = i_wr && (i_addr == scr_pkg::MODE_OFS);
   wire wr_stat = i_wr && (i_addr == scr_pkg::STAT_OFS);
   wire wr_txd  = i_wr && (i_addr == scr_pkg::TXD_OFS);
   wire rd_rxd  = i_rd && (i_addr == scr_pkg::RXD_OFS);

   // pin side after synchronisers
   wire rxd      = rxd_s_q[1];
   wire sck_in   = sck_s_q[1];
   wire sck_rise = sck_in && !sck_d_q;
   wire sck_fall = !sck_in && sck_d_q;

   wire async_mode = !mode_q.sync_mode;
   wire mp_frame   = async_mode && mode_q.multiproc_format;
   wire filter_on  = ctrl_q.mp_filter_en && mp_frame;
   wire ext_clk    = ctrl_q.clk_sel_hi;
   wire int_tick   = (div_q == DIV_LAST);
   wire tick16     = ext_clk ? sck_rise : int_tick;
   wire int_fall   = int_tick && (phase_q == scr_pkg::SYNC_PHASE_FALL);
   wire int_rise   = int_tick && (phase_q == scr_pkg::SYNC_PHASE_RISE);
   wire s_fall     = ext_clk ? sck_fall : int_fall;
   wire s_rise     = ext_clk ? sck_rise : int_rise;

   wire tx_busy  = (tx_state_q == TX_BUSY);
   wire tx_load  = !tx_busy && ctrl_q.tx_enable && txb_valid
                   && (async_mode ? tick16 : s_fall);
   wire tx_end   = !tx_busy && !txb_valid;

   // receive outcome of the frame that completes this cycle
   wire rx_stop_ok = !async_mode || (mp_frame ? rx_sh_d[9] : rx_sh_d[8]);
   wire rx_discard = filter_on && !rx_word.mp_bit;
   wire mp_hit     = rx_done && filter_on && rx_word.mp_bit;
   wire rx_accept  = rx_done && !rx_discard;
   wire rx_push    = rx_accept && rx_stop_ok;
   wire set_ovr    = rx_push && !rxb_ready;
   wire set_fer    = rx_accept && !rx_stop_ok;

   assign rx_word.data   = rx_sh_d[7:0];
   assign rx_word.mp_bit = mp_frame && rx_sh_d[8];
   assign txb_data.data   = i_wdata;
   assign txb_data.mp_bit = mode_q.tx_mp_bit;

   // the transmit buffer refuses a write while full; software watches the empty flag
   scr_buf2 #(
      .W ($bits(scr_pkg::scr_word_type))
   ) u_tx_buf (
      .i_clk       (i_clk),
      .i_rstn      (i_rstn),
      .i_in_valid  (wr_txd),
      .o_in_ready  (txb_ready),
      .i_in_data   (txb_data),
      .o_out_valid (txb_valid),
      .i_out_ready (tx_load),
      .o_out_data  (txb_head)
   );

   // a stalled software reader fills this buffer; further frames then overrun
   scr_buf2 #(
      .W ($bits(scr_pkg::scr_word_type))
   ) u_rx_buf (
      .i_clk       (i_clk),
      .i_rstn      (i_rstn),
      .i_in_valid  (rx_push),
      .o_in_ready  (rxb_ready),
      .i_in_data   (rx_word),
      .o_out_valid (rxb_valid),
      .i_out_ready (rd_rxd),
      .o_out_data  (rxb_out)
   );

   // control register: a software write takes priority over the hardware clear
   always_comb begin
      ctrl_d = ctrl_q;
      if (wr_ctrl) begin
         ctrl_d = scr_pkg::scr_ctrl_type'(i_wdata);
      end else if (mp_hit) begin
         ctrl_d.mp_filter_en = 1'b0;
      end
   end

   wire [7:0] stat_word = {txb_ready, rxb_valid, overrun_q, framing_q,
                           1'b0, tx_end, rxb_out.mp_bit, 1'b0};

   always_comb begin
      rdata_d = 8'h00;
      if (i_rd) begin
         case (i_addr)
            scr_pkg::CTRL_OFS: rdata_d = ctrl_q;
            scr_pkg::MODE_OFS: rdata_d = mode_q;
            scr_pkg::STAT_OFS: rdata_d = stat_word;
            scr_pkg::RXD_OFS:  rdata_d = rxb_out.data;
            default:           rdata_d = 8'h00;
         endcase
      end
   end

   // transmitter
   always_comb begin
      tx_state_d = tx_state_q;
      tx_sh_d    = tx_sh_q;
      tx_cnt_d   = tx_cnt_q;
      tx_tick_d  = tx_tick_q;
      case (tx_state_q)
         TX_IDLE: begin
            if (tx_load) begin
               tx_state_d = TX_BUSY;
               // the load tick is not counted; the start bit lasts sixteen further ticks
               tx_tick_d  = 4'h0;
               if (async_mode) begin
                  tx_sh_d  = {1'b1, (mp_frame ? txb_head.mp_bit : 1'b1), txb_head.data, 1'b0};
                  tx_cnt_d = mp_frame ? scr_pkg::ASYNC_BITS_MP : scr_pkg::ASYNC_BITS;
               end else begin
                  tx_sh_d  = {3'h7, txb_head.data};
                  tx_cnt_d = scr_pkg::SYNC_BITS;
               end
            end
         end
         TX_BUSY: begin
            if (!ctrl_q.tx_enable) begin
               tx_state_d = TX_IDLE;
               tx_sh_d    = scr_pkg::TX_IDLE_LINE;
            end else if (async_mode) begin
               if (tick16) begin
                  tx_tick_d = tx_tick_q + 4'h1;
                  if (tx_tick_q == scr_pkg::TICK_LAST) begin
                     tx_sh_d  = {1'b1, tx_sh_q[10:1]};
                     tx_cnt_d = tx_cnt_q - 4'h1;
                     if (tx_cnt_q == 4'h1) begin
                        tx_state_d = TX_IDLE;
                     end
                  end
               end
            end else begin
               if (s_fall) begin
                  tx_sh_d = {1'b1, tx_sh_q[10:1]};
               end
               if (s_rise) begin
                  tx_cnt_d = tx_cnt_q - 4'h1;
                  if (tx_cnt_q == 4'h1) begin
                     tx_state_d = TX_IDLE;
                     tx_sh_d    = scr_pkg::TX_IDLE_LINE;
                  end
               end
            end
         end
         default: begin
            tx_state_d = TX_IDLE;
            tx_sh_d    = scr_pkg::TX_IDLE_LINE;
         end
      endcase
   end

   // receiver; in synchronous mode with internal clock it samples on every internal rise, sending or not
   always_comb begin
      rx_state_d = rx_state_q;
      rx_sh_d    = rx_sh_q;
      rx_idx_d   = rx_idx_q;
      rx_tick_d  = rx_tick_q;
      rx_done    = 1'b0;
      if (!ctrl_q.rx_enable) begin
         rx_state_d = RX_IDLE;
         rx_idx_d   = 4'h0;
      end else if (!async_mode) begin
         if (s_rise) begin
            rx_sh_d[rx_idx_q] = rxd;
            rx_idx_d = rx_idx_q + 4'h1;
            if (rx_idx_q == scr_pkg::SYNC_LAST_IDX) begin
               rx_done  = 1'b1;
               rx_idx_d = 4'h0;
            end
         end
      end else begin
         case (rx_state_q)
            RX_IDLE: begin
               if (tick16 && !rxd) begin
                  rx_state_d = RX_START;
                  rx_tick_d  = scr_pkg::TICK_FIRST;
               end
            end
            RX_START: begin
               if (tick16) begin
                  rx_tick_d = rx_tick_q + 4'h1;
                  if (rx_tick_q == scr_pkg::TICK_MID) begin
                     // a start bit gone by mid-bit was a glitch
                     rx_state_d = rxd ? RX_IDLE : RX_BITS;
                     rx_tick_d  = 4'h0;
                     rx_idx_d   = 4'h0;
                  end
               end
            end
            RX_BITS: begin
               if (tick16) begin
                  rx_tick_d = rx_tick_q + 4'h1;
                  if (rx_tick_q == scr_pkg::TICK_LAST) begin
                     rx_sh_d[rx_idx_q] = rxd;
                     rx_idx_d = rx_idx_q + 4'h1;
                     if (rx_idx_q == (mp_frame ? scr_pkg::RX_LAST_IDX_MP
                                               : scr_pkg::RX_LAST_IDX)) begin
                        rx_done    = 1'b1;
                        rx_state_d = RX_IDLE;
                        rx_idx_d   = 4'h0;
                     end
                  end
               end
            end
            default: begin
               rx_state_d = RX_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         ctrl_q    <= scr_pkg::CTRL_RESET;
         mode_q    <= scr_pkg::MODE_RESET;
         overrun_q <= 1'b0;
         framing_q <= 1'b0;
         rdata_q   <= 8'h00;
      end else begin
         ctrl_q    <= ctrl_d;
         rdata_q   <= rdata_d;
         if (wr_mode) begin
            mode_q <= scr_pkg::scr_mode_type'({5'h00, i_wdata[2:0]});
         end
         overrun_q <= sticky_next(overrun_q, set_ovr,
                                  wr_stat && !i_wdata[scr_pkg::ST_OVERRUN]);
         framing_q <= sticky_next(framing_q, set_fer,
                                  wr_stat && !i_wdata[scr_pkg::ST_FRAMING]);
      end
   end

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         rxd_s_q <= 2'h3;
         // reset to the pin's idle-high level so no false edge follows reset
         sck_s_q <= 2'h3;
         sck_d_q <= 1'b1;
         div_q   <= 16'h0000;
         phase_q <= 4'h0;
      end else begin
         rxd_s_q <= {rxd_s_q[0], i_rxd};
         sck_s_q <= {sck_s_q[0], i_sck};
         sck_d_q <= sck_in;
         div_q   <= int_tick ? 16'h0000 : div_q + 16'h0001;
         if (int_tick) begin
            phase_q <= phase_q + 4'h1;
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         tx_state_q <= TX_IDLE;
         tx_sh_q    <= scr_pkg::TX_IDLE_LINE;
         tx_cnt_q   <= 4'h0;
         tx_tick_q  <= 4'h0;
         rx_state_q <= RX_IDLE;
         rx_sh_q    <= scr_pkg::RX_SH_RESET;
         rx_idx_q   <= 4'h0;
         rx_tick_q  <= 4'h0;
      end else begin
         tx_state_q <= tx_state_d;
         tx_sh_q    <= tx_sh_d;
         tx_cnt_q   <= tx_cnt_d;
         tx_tick_q  <= tx_tick_d;
         rx_state_q <= rx_state_d;
         rx_sh_q    <= rx_sh_d;
         rx_idx_q   <= rx_idx_d;
         rx_tick_q  <= rx_tick_d;
      end
   end

   // serial clock pin: bit-rate clock is high in the first half of each phase cycle
   wire async_out = async_mode && !ctrl_q.clk_sel_hi && ctrl_q.clk_sel_lo;
   wire sync_out  = !async_mode && !ctrl_q.clk_sel_hi;
   wire sck_oe_d  = async_out || sync_out;
   wire sck_d     = async_out ? !phase_q[3]
                  : (sync_out ? !(tx_busy && phase_q[3]) : 1'b1);

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         sck_q    <= 1'b1;
         sck_oe_q <= 1'b0;
      end else begin
         sck_q    <= sck_d;
         sck_oe_q <= sck_oe_d;
      end
   end

   assign o_rdata  = rdata_q;
   assign o_txd    = tx_sh_q[0];
   assign o_sck    = sck_q;
   assign o_sck_oe = sck_oe_q;

   // requests follow their conditions combinationally so a clear drops them at once
   assign o_tx_empty_irq = txb_ready && ctrl_q.tx_empty_irq_en;
   assign o_rx_full_irq  = rxb_valid && ctrl_q.rx_irq_en;
   assign o_rx_error_irq = (overrun_q || framing_q) && ctrl_q.rx_irq_en;
   assign o_tx_end_irq   = tx_end && ctrl_q.tx_end_irq_en;

endmodule : scr_serial_control

// ### src/scr_pkg.sv
/*
 * Shared constants and types of the serial control register block: register offsets,
 * field layouts, reset values and bit-timing counts.
 * Assumes a 100 MHz system clock and an 8-bit register port with a 3-bit word address.
 */
package scr_pkg;

   localparam int unsigned CLK_HZ = 100_000_000;

   // register offsets on the plain register port
   localparam logic [2:0] CTRL_OFS = 3'h0;
   localparam logic [2:0] MODE_OFS = 3'h1;
   localparam logic [2:0] STAT_OFS = 3'h2;
   localparam logic [2:0] TXD_OFS  = 3'h3;
   localparam logic [2:0] RXD_OFS  = 3'h4;

   typedef struct packed {
      logic tx_empty_irq_en;
      logic rx_irq_en;
      logic tx_enable;
      logic rx_enable;
      logic mp_filter_en;
      logic tx_end_irq_en;
      logic clk_sel_hi;
      logic clk_sel_lo;
   } scr_ctrl_type;

   typedef struct packed {
      logic [4:0] reserved;
      logic       tx_mp_bit;
      logic       multiproc_format;
      logic       sync_mode;
   } scr_mode_type;

   typedef struct packed {
      logic       mp_bit;
      logic [7:0] data;
   } scr_word_type;

   localparam scr_ctrl_type CTRL_RESET = scr_ctrl_type'(8'h00);
   localparam scr_mode_type MODE_RESET = scr_mode_type'(8'h00);

   // status register bit positions
   localparam int unsigned ST_TX_EMPTY = 7;
   localparam int unsigned ST_RX_FULL  = 6;
   localparam int unsigned ST_OVERRUN  = 5;
   localparam int unsigned ST_FRAMING  = 4;
   localparam int unsigned ST_TX_END   = 2;
   localparam int unsigned ST_RX_MP    = 1;

   // bit timing in ticks of the sixteen-times clock
   localparam int unsigned TICKS_PER_BIT = 16;
   localparam logic [3:0]  TICK_LAST     = 4'hF;
   localparam logic [3:0]  TICK_MID      = 4'h7;
   localparam logic [3:0]  TICK_FIRST    = 4'h1;
   localparam logic [3:0]  SYNC_PHASE_FALL = 4'h7;
   localparam logic [3:0]  SYNC_PHASE_RISE = 4'hF;

   // frame lengths in bits and last receive bit indexes
   localparam logic [3:0]  ASYNC_BITS    = 4'hA;
   localparam logic [3:0]  ASYNC_BITS_MP = 4'hB;
   localparam logic [3:0]  SYNC_BITS     = 4'h8;
   localparam logic [3:0]  RX_LAST_IDX   = 4'h8;
   localparam logic [3:0]  RX_LAST_IDX_MP = 4'h9;
   localparam logic [3:0]  SYNC_LAST_IDX = 4'h7;

   localparam logic [10:0] TX_IDLE_LINE  = 11'h7FF;
   localparam logic [9:0]  RX_SH_RESET   = 10'h000;

endpackage : scr_pkg

// ### src/scr_buf2.sv
/*
 * Two-entry buffer with valid and ready on both sides.
 * Assumes the filling and draining sides run on the same clock as the buffer.
 */
module scr_buf2 #(
   parameter int unsigned W = 9
) (
   input  wire logic         i_clk,
   input  wire logic         i_rstn,
   input  wire logic         i_in_valid,
   output logic              o_in_ready,
   input  wire logic [W-1:0] i_in_data,
   output logic              o_out_valid,
   input  wire logic         i_out_ready,
   output logic [W-1:0]      o_out_data
);

   logic [W-1:0] mem_q [2];
   logic [1:0]   count_q;
   logic [1:0]   count_d;
   logic         wp_q;
   logic         rp_q;

   wire push = i_in_valid && o_in_ready;
   wire pop  = o_out_valid && i_out_ready;

   assign o_in_ready  = (count_q != 2'h2);
   assign o_out_valid = (count_q != 2'h0);
   assign o_out_data  = mem_q[rp_q];

   always_comb begin
      count_d = count_q;
      if (push && !pop) begin
         count_d = count_q + 2'h1;
      end else if (pop && !push) begin
         count_d = count_q - 2'h1;
      end
   end

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         count_q  <= 2'h0;
         wp_q     <= 1'b0;
         rp_q     <= 1'b0;
         mem_q[0] <= '0;
         mem_q[1] <= '0;
      end else begin
         count_q <= count_d;
         if (push) begin
            mem_q[wp_q] <= i_in_data;
            wp_q        <= !wp_q;
         end
         if (pop) begin
            rp_q <= !rp_q;
         end
      end
   end

endmodule : scr_buf2

// ### dv/scl_peer.sv
/* Peer serial device beside the receive line and the clock pin.
   Assumes the bench calls send and feeds the clock to the pin only while
   the block does not drive it. */
module scl_peer (
   output logic o_rxd,
   output logic o_sck
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      o_rxd = 1'b1;
      o_sck = 1'b1;
   end
   // the clock stands still between frames; the line rests high like a stop bit
   task automatic send(input logic [7:0] b, input logic tag, input logic has_tag);
      logic [10:0] f;
      f = has_tag ? {1'b1, tag, b, 1'b0} : {2'b11, b, 1'b0};
      #3;
      for (int i = 0; i < (has_tag ? 11 : 10); i++) begin
         o_rxd = f[i];
         repeat (16) begin
            #80 o_sck = 1'b0;
            #80 o_sck = 1'b1;
         end
      end
   endtask : send
endmodule : scl_peer

// ### dv/scl_ctrl_props.sv
/* Port checker of the serial control register block.
   Assumes binding to scr_serial_control; it keeps a shadow of software writes. */
module scl_ctrl_props (
   input wire logic       i_clk,
   input wire logic       i_rstn,
   input wire logic [2:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic       i_wr,
   input wire logic       i_rd,
   input wire logic [7:0] o_rdata,
   input wire logic       o_txd,
   input wire logic       o_sck_oe,
   input wire logic       o_tx_empty_irq,
   input wire logic       o_rx_full_irq,
   input wire logic       o_rx_error_irq,
   input wire logic       o_tx_end_irq
);
   logic [7:0] ctl_q;
   logic       sync_q;
   // the filter bit alone may be cleared by hardware, so a read may only show it set if it was written set
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         ctl_q  <= 8'h00;
         sync_q <= 1'b0;
      end else if (i_wr && i_addr == scr_pkg::CTRL_OFS) begin
         ctl_q <= i_wdata;
      end else if (i_wr && i_addr == scr_pkg::MODE_OFS) begin
         sync_q <= i_wdata[0];
      end
   end
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rstn);
   property p_txe; !ctl_q[7] |-> !o_tx_empty_irq; endproperty
   a_txe: assert property (p_txe) else $error("tx empty request unmasked");
   property p_rxm; !ctl_q[6] |-> !o_rx_full_irq && !o_rx_error_irq; endproperty
   a_rxm: assert property (p_rxm) else $error("rx request unmasked");
   property p_tend; !ctl_q[2] |-> !o_tx_end_irq; endproperty
   a_tend: assert property (p_tend) else $error("tx end request unmasked");
   property p_idle; o_tx_end_irq |-> o_txd; endproperty
   a_idle: assert property (p_idle) else $error("tx end while line busy");
   property p_txoff; !ctl_q[5] [*4] |-> o_txd; endproperty
   a_txoff: assert property (p_txoff) else $error("sending while disabled");
   property p_rxoff; (!ctl_q[4] && $stable(ctl_q)) [*4] |-> !$rose(o_rx_full_irq); endproperty
   a_rxoff: assert property (p_rxoff) else $error("word taken while disabled");
   property p_pgp; (!sync_q && ctl_q[1:0] == 2'b00) [*2] |-> !o_sck_oe; endproperty
   a_pgp: assert property (p_pgp) else $error("pin driven in port use");
   property p_pout; (!sync_q && ctl_q[1:0] == 2'b01) [*2] |-> o_sck_oe; endproperty
   a_pout: assert property (p_pout) else $error("bit clock not driven");
   property p_pin; ctl_q[1] [*2] |-> !o_sck_oe; endproperty
   a_pin: assert property (p_pin) else $error("pin driven in external mode");
   property p_psy; (sync_q && !ctl_q[1]) [*2] |-> o_sck_oe; endproperty
   a_psy: assert property (p_psy) else $error("transfer clock not driven");
   property p_rd;
      i_rd && i_addr == scr_pkg::CTRL_OFS |=> (o_rdata & 8'hF7) == ($past(ctl_q) & 8'hF7)
         && (!o_rdata[3] || $past(ctl_q[3]));
   endproperty
   a_rd: assert property (p_rd) else $error("control read back wrong");
endmodule : scl_ctrl_props
bind scr_serial_control scl_ctrl_props i_scl_ctrl_props (.i_clk, .i_rstn, .i_addr, .i_wdata,
   .i_wr, .i_rd, .o_rdata, .o_txd, .o_sck_oe, .o_tx_empty_irq, .o_rx_full_irq,
   .o_rx_error_irq, .o_tx_end_irq);

// ### dv/tb_scr_serial_control.sv
/* Self-checking bench of the serial control register block.
   Assumes package, design, peer model and checker are compiled before it. */
module tb_scr_serial_control;
   timeunit 1ns;
   timeprecision 1ps;
   logic       i_clk, i_rstn, wr, rd, txd, sck, sck_oe, pk_rxd, pk_sck;
   logic       irq_txe, irq_rxf, irq_err, irq_done;
   logic [2:0] addr;
   logic [7:0] wdata, rdata, v;
   int         err_count = 0;
   int         checks = 0;
   wire        sck_w = sck_oe ? sck : pk_sck;
   scr_serial_control #(.BAUD(3125000)) i_scr_serial_control (.i_clk, .i_rstn,
      .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
      .i_rxd(pk_rxd), .o_txd(txd), .i_sck(sck_w), .o_sck(sck), .o_sck_oe(sck_oe),
      .o_tx_empty_irq(irq_txe), .o_rx_full_irq(irq_rxf), .o_rx_error_irq(irq_err),
      .o_tx_end_irq(irq_done));
   scl_peer i_scl_peer (.o_rxd(pk_rxd), .o_sck(pk_sck));
   initial begin
      i_clk = 1'b0;
      forever #5 i_clk = ~i_clk;
   end
   task automatic chk(input logic [7:0] s, input logic [7:0] e);
      checks++;
      if (s !== e) begin
         err_count++;
         $display("unexpected at %0t ns: saw %h, expected %h", $time, s, e);
      end
   endtask : chk
   task automatic report_and_stop;
      $display("checks %0d, mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : report_and_stop
   task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge i_clk);
      wr <= 1'b0;
      @(posedge i_clk);
   endtask : wr_reg
   task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
      addr <= a;
      rd   <= 1'b1;
      @(posedge i_clk);
      rd <= 1'b0;
      #1 d = rdata;
      @(posedge i_clk);
   endtask : rd_reg
   // one frame from the peer, then time for the synchroniser to land it
   task automatic rx_frame(input logic [7:0] b, input logic tag, input logic has_tag);
      i_scl_peer.send(b, tag, has_tag);
      @(posedge i_clk);
      repeat (4) @(posedge i_clk);
   endtask : rx_frame
   task automatic t_regs;
      rd_reg(scr_pkg::CTRL_OFS, v);
      chk(v, 8'h00);
      chk({4'h0, irq_txe, irq_rxf, irq_err, irq_done}, 8'h00);
      wr_reg(scr_pkg::CTRL_OFS, 8'hF7);
      rd_reg(scr_pkg::CTRL_OFS, v);
      chk(v, 8'hF7);
      rd_reg(3'h7, v);
      chk(v, 8'h00);
      wr_reg(scr_pkg::CTRL_OFS, 8'h84);
      chk({6'h00, irq_txe, irq_done}, 8'h03);
      wr_reg(scr_pkg::CTRL_OFS, 8'h00);
      chk({6'h00, irq_txe, irq_done}, 8'h00);
      $display("t_regs done");
   endtask : t_regs
   task automatic t_clk_modes;
      logic [3:0] tab [8] = '{4'h0, 4'h3, 4'h4, 4'h6, 4'h9, 4'hB, 4'hC, 4'hE};
      int         n;
      foreach (tab[i]) begin
         wr_reg(scr_pkg::MODE_OFS, {7'h00, tab[i][3]});
         wr_reg(scr_pkg::CTRL_OFS, {6'h00, tab[i][2:1]});
         @(posedge i_clk);
         chk({7'h00, sck_oe}, {7'h00, tab[i][0]});
      end
      wr_reg(scr_pkg::MODE_OFS, 8'h00);
      wr_reg(scr_pkg::CTRL_OFS, 8'h01);
      n = 0;
      #1 v[0] = sck;
      repeat (128) begin
         @(posedge i_clk);
         #1 n += int'(sck !== v[0]);
         v[0] = sck;
      end
      chk(8'(n), 8'h08);
      $display("t_clk_modes done");
   endtask : t_clk_modes
   task automatic t_tx;
      int   n;
      logic hi;
      wr_reg(scr_pkg::CTRL_OFS, 8'h04);
      wr_reg(scr_pkg::TXD_OFS, 8'h55);
      hi = 1'b1;
      repeat (200) begin
         @(posedge i_clk);
         hi &= txd;
      end
      chk({7'h00, hi}, 8'h01);
      wr_reg(scr_pkg::CTRL_OFS, 8'h24);
      for (n = 0; n < 300 && txd !== 1'b0; n++) @(posedge i_clk);
      if (n == 300) begin
         err_count++;
         report_and_stop();
      end
      chk({7'h00, irq_done}, 8'h00);
      // mid-bit samples: a bit lasts 32 cycles at this bit rate
      repeat (16) @(posedge i_clk);
      for (int i = 0; i < 8; i++) begin
         repeat (32) @(posedge i_clk);
         v[i] = txd;
      end
      chk(v, 8'h55);
      wr_reg(scr_pkg::CTRL_OFS, 8'h00);
      repeat (4) @(posedge i_clk);
      chk({7'h00, txd}, 8'h01);
      $display("t_tx done");
   endtask : t_tx
   task automatic t_rx;
      wr_reg(scr_pkg::MODE_OFS, 8'h02);
      wr_reg(scr_pkg::CTRL_OFS, 8'h52);
      rx_frame(8'h5A, 1'b0, 1'b1);
      chk({7'h00, irq_rxf}, 8'h01);
      rd_reg(scr_pkg::RXD_OFS, v);
      chk(v, 8'h5A);
      wr_reg(scr_pkg::CTRL_OFS, 8'h5A);
      rx_frame(8'h33, 1'b0, 1'b1);
      rd_reg(scr_pkg::STAT_OFS, v);
      chk(v & 8'h70, 8'h00);
      rx_frame(8'hC3, 1'b1, 1'b1);
      chk({7'h00, irq_rxf}, 8'h01);
      rd_reg(scr_pkg::CTRL_OFS, v);
      chk(v, 8'h52);
      rd_reg(scr_pkg::RXD_OFS, v);
      chk(v, 8'hC3);
      wr_reg(scr_pkg::CTRL_OFS, 8'h42);
      rx_frame(8'h11, 1'b0, 1'b1);
      chk({7'h00, irq_rxf}, 8'h00);
      wr_reg(scr_pkg::MODE_OFS, 8'h00);
      wr_reg(scr_pkg::CTRL_OFS, 8'h5A);
      rx_frame(8'h77, 1'b0, 1'b0);
      rd_reg(scr_pkg::RXD_OFS, v);
      chk(v, 8'h77);
      // a ninth bit of 0 lands where a plain frame expects its stop bit
      rx_frame(8'h00, 1'b0, 1'b1);
      chk({7'h00, irq_err}, 8'h01);
      $display("t_rx done");
   endtask : t_rx
   initial begin
      #900us;
      err_count++;
      report_and_stop();
   end
   initial begin
      i_rstn = 1'b0;
      wr     = 1'b0;
      rd     = 1'b0;
      addr   = 3'h0;
      wdata  = 8'h00;
      repeat (16) @(posedge i_clk);
      i_rstn <= 1'b1;
      @(posedge i_clk);
      t_regs();
      t_clk_modes();
      t_tx();
      t_rx();
      report_and_stop();
   end
endmodule : tb_scr_serial_control
